/* File: stx_cfg.svh */
// Purpose: constants of the sent transmitter: register map, field positions, reset values, timing
// Assumes: 10 MHz mclk, 32-bit avalon-mm register slave with byte addresses
// Notes:   tick periods are kept in 25 ns units so quarter-microsecond steps stay exact
`ifndef STX_CFG_SVH
`define STX_CFG_SVH

// register byte offsets
`define STX_CTRL_OFS      4'h0
`define STX_MSG_OFS       4'h4
`define STX_STAT_OFS      4'h8

// control register fields
`define STX_DOS_LSB       0
`define STX_ESM_BIT       2
`define STX_RCDIS_BIT     3
`define STX_PP_BIT        4
`define STX_FBS_BIT       5
`define STX_TK_LSB        8
`define STX_DOS_SENT      2'h3
`define STX_CTRL_RESET    32'h0000_0000

// message register fields
`define STX_MID_LSB       0
`define STX_MAG_LSB       8
`define STX_MSG_RESET     32'h0000_0000

// status register fields
`define STX_ST_ERR_BIT    0
`define STX_ST_WD_BIT     1
`define STX_ST_ADC_BIT    2
`define STX_ST_SIG_BIT    3
`define STX_ST_ACT_BIT    4
`define STX_ST_ROLL_LSB   8

// frame timing in ticks
`define STX_SYNC_TICKS    8'h38
`define STX_LOW_TICKS     8'h05
`define STX_NIB_BASE      8'h0c
`define STX_FRAME_TICKS   9'h110

// crc
`define STX_CRC_SEED      4'h5
`define STX_CRC_POLY      4'hd

// tick generation
`define STX_CLK_PERIOD_NS 100
`define STX_TICK_UNIT_NS  25
`define STX_ACC_STEP      (`STX_CLK_PERIOD_NS / `STX_TICK_UNIT_NS)

`endif

/* File: stx_pkg.sv */
// Purpose: types shared by the sent transmitter modules
// Assumes: constants live in stx_cfg.svh
// Notes:   state of each module is one packed struct
package stx_pkg;

   typedef enum logic [1:0] {PH_IDLE, PH_SYNC, PH_NIB, PH_PAUSE} stx_phase_e;

   typedef struct packed {
      stx_phase_e       ph;
      logic [7:0]       cnt;
      logic [8:0]       ft;
      logic [2:0]       idx;
      logic [6:0][3:0]  nib;
      logic [7:0]       pl;
      logic [7:0]       roll;
      logic [3:0]       msgIdx;
      logic [15:0]      msgw;
      logic             line;
      logic             drv;
      logic             wdL;
      logic             adcL;
      logic             sigL;
      logic [1:0]       dos;
      logic             esm;
      logic             rcDis;
      logic             pp;
      logic             failure_band_select;
      logic [4:0]       tk;
      logic [3:0]       mid;
      logic [7:0]       field_magnitude;
      logic             ack;
      logic [31:0]      rdata;
   } stx_state_s;

   typedef struct packed {
      logic [9:0] acc;
   } stx_tick_s;

endpackage

/* File: stx_if.sv */
// Purpose: carriers between the transmitter core, its tick generator and its crc units
// Assumes: all signals on mclk
// Notes:   crc carrier width follows the nibble count
`timescale 1ns/1ps
interface stx_tick_if;
   logic       tickEn;
   logic [4:0] tickCode;
   logic       tick;
   modport gen (input tickEn, input tickCode, output tick);
   modport use_ (output tickEn, output tickCode, input tick);
endinterface

interface stx_crc_if #(parameter int N = 6);
   logic [4*N-1:0] data;
   logic [3:0]     crc;
   modport calc (input data, output crc);
   modport user (output data, input crc);
endinterface

/* File: stx_tick.sv */
// Purpose: sent tick strobe from mclk by a fractional accumulator
// Assumes: tick period is at least two mclk periods
// Notes:   jitter of one mclk period on each tick is traded for exact mean period
`timescale 1ns/1ps
`include "stx_cfg.svh"
module stx_tick (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // tick carrier
   stx_tick_if.gen  tif
);
   stx_pkg::stx_tick_s st;
   stx_pkg::stx_tick_s next_st;
   logic [9:0]         per;
   logic [9:0]         sum;

   // period in 25 ns units
   function automatic logic [9:0] period(input logic [4:0] code);
      unique case (code)
         5'h00: period = 10'h078;
         5'h01: period = 10'h0a0;
         5'h02: period = 10'h0b4;
         5'h03: period = 10'h0c8;
         5'h04: period = 10'h0dc;
         5'h05: period = 10'h0e6;
         5'h06: period = 10'h104;
         5'h07: period = 10'h10e;
         5'h08: period = 10'h12c;
         5'h09: period = 10'h140;
         5'h0a: period = 10'h154;
         5'h0b: period = 10'h168;
         5'h0c: period = 10'h17c;
         5'h0d: period = 10'h190;
         5'h0e: period = 10'h19a;
         5'h0f: period = 10'h1a4;
         5'h10: period = 10'h1ae;
         5'h11: period = 10'h1b8;
         5'h12: period = 10'h1c2;
         5'h13: period = 10'h1cc;
         5'h14: period = 10'h1d6;
         5'h15: period = 10'h1e0;
         5'h16: period = 10'h1ea;
         5'h17: period = 10'h1f4;
         5'h18: period = 10'h05a;
         5'h19: period = 10'h064;
         5'h1a: period = 10'h06e;
         5'h1b: period = 10'h078;
         5'h1c: period = 10'h082;
         5'h1d, 5'h1e, 5'h1f: period = 10'h08c;
      endcase
   endfunction

   always_comb begin
      next_st = st;
      per = period(tif.tickCode); // R5
      sum = st.acc + 10'(`STX_ACC_STEP);
      tif.tick = 1'b0;
      if (!tif.tickEn) begin
         next_st.acc = 10'h000;
      end else if (sum >= per) begin
         tif.tick = 1'b1;
         next_st.acc = sum - per;
      end else begin
         next_st.acc = sum;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   AST_TICK_SPACED: assert property (@(posedge mclk) disable iff (reset) tif.tick |=> !tif.tick) // R5
      else $error("ticks on adjacent clocks");
endmodule

/* File: stx_crc4.sv */
// Purpose: 4-bit sent crc over a string of nibbles, first nibble first
// Assumes: seed and polynomial from stx_cfg.svh
// Notes:   one trailing zero nibble is folded in, as the recommended sent form asks
`timescale 1ns/1ps
`include "stx_cfg.svh"
module stx_crc4 #(
   parameter int N = 6
) (
   // crc carrier
   stx_crc_if.calc cif
);
   if (N < 1) begin : g_chk
      $error("stx_crc4 needs at least one nibble");
   end

   function automatic logic [3:0] mulx4(input logic [3:0] c);
      logic [3:0] r;
      r = c;
      for (int b = 0; b < 4; b++) begin
         r = r[3] ? ({r[2:0], 1'b0} ^ `STX_CRC_POLY) : {r[2:0], 1'b0};
      end
      return r;
   endfunction

   always_comb begin
      logic [3:0] c;
      c = `STX_CRC_SEED;
      for (int i = N - 1; i >= 0; i--) begin
         c = mulx4(c) ^ cif.data[4*i +: 4];
      end
      cif.crc = mulx4(c);
   end
endmodule

/* File: stx_sent_tx.sv */
// Purpose: sent telegram transmitter with avalon-mm register slave
// Assumes: fault inputs and angle come from logic on mclk; reset synchronous, active high
// Notes:   one wait state on every bus access
// How it works
// R1: transmitter drives line only while output select chooses sent
// R2: telegrams repeat continuously with no request from receiver
// R3: each telegram starts with 56-tick sync then eight nibbles
// R4: nibble is 5 ticks low then 7 plus value ticks high
// R5: 5-bit code selects tick period from fixed table
// R6: nibble order status, angle msb first, counter, inverted nibble 2, crc
// R7: status bit0 error, bit1 zero, bit2 message bit, bit3 message start
// R8: 16-bit message sent one bit per telegram, start flag on first
// R9: message holds id, field magnitude and a trailing 4-bit crc
// R10: serial message sent only when enabled, disabled after reset
// R11: rolling counter steps once per telegram, wraps after 255
// R12: a control bit disables the rolling counter
// R13: pause pulse enabled stretches every telegram to 272 ticks
// R14: watchdog failure reported until reset
// R15: adc check or signature failure latch failure band until reset
// R16: offset, cordic overflow, field range faults force band while present
// R17: band select chooses lower or upper failure band
// R18: nibble 8 is crc over nibbles 2 to 7, seed 0101
// R19: disabled counter sends zero in nibbles 5 and 6
// R20: receiver times falling edges and decodes interval minus twelve
`timescale 1ns/1ps
`include "stx_cfg.svh"
module stx_sent_tx (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // sensor core
   input  wire logic [11:0] angle,
   input  wire logic        watchdogFault,
   input  wire logic        adcCheckFault,
   input  wire logic        signatureFault,
   input  wire logic        offsetFault,
   input  wire logic        cordicOverflow,
   input  wire logic        fieldRangeFault,
   // sent line
   output logic             sentData,
   output logic             sentDriveEn
);
   stx_pkg::stx_state_s st;
   stx_pkg::stx_state_s next_st;
   logic                busReq;
   logic                sentMode;
   logic                tick;
   logic                segEnd;
   logic                startFrame;
   logic                faultNow;
   logic [3:0]          curNib;
   logic [11:0]         angleOut;
   logic [7:0]          rollOut;
   logic [8:0]          ftNext;
   logic [15:0]         msgLive;

   stx_tick_if      tif ();
   stx_crc_if #(6)  fcrc ();
   stx_crc_if #(3)  mcrc ();

   stx_tick        u_tick (.mclk(mclk), .reset(reset), .tif(tif));
   stx_crc4 #(6)   u_fcrc (.cif(fcrc));
   stx_crc4 #(3)   u_mcrc (.cif(mcrc));

   assign tif.tickEn   = (st.ph != stx_pkg::PH_IDLE);
   assign tif.tickCode = st.tk;
   assign tick         = tif.tick;
   assign fcrc.data    = {st.nib[1], st.nib[2], st.nib[3], st.nib[4], st.nib[5], st.nib[6]}; // R18
   assign mcrc.data    = {st.mid, st.field_magnitude}; // R9
   assign msgLive      = {st.mid, st.field_magnitude, mcrc.crc}; // R9

   // length of the running segment in ticks
   function automatic logic [7:0] segLen(input stx_pkg::stx_phase_e ph, input logic [3:0] n,
                                         input logic [7:0] pl);
      unique case (ph)
         stx_pkg::PH_SYNC:  segLen = `STX_SYNC_TICKS;
         stx_pkg::PH_NIB:   segLen = `STX_NIB_BASE + {4'h0, n};
         stx_pkg::PH_PAUSE: segLen = pl;
         stx_pkg::PH_IDLE:  segLen = 8'h01;
      endcase
   endfunction

   function automatic logic [31:0] readMux(input stx_pkg::stx_state_s s, input logic [3:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a)
         `STX_CTRL_OFS: begin
            r[`STX_DOS_LSB +: 2] = s.dos;
            r[`STX_ESM_BIT]      = s.esm;
            r[`STX_RCDIS_BIT]    = s.rcDis;
            r[`STX_PP_BIT]       = s.pp;
            r[`STX_FBS_BIT]      = s.failure_band_select;
            r[`STX_TK_LSB +: 5]  = s.tk;
         end
         `STX_MSG_OFS: begin
            r[`STX_MID_LSB +: 4] = s.mid;
            r[`STX_MAG_LSB +: 8] = s.field_magnitude;
         end
         `STX_STAT_OFS: begin
            r[`STX_ST_ERR_BIT]      = s.wdL | s.adcL | s.sigL;
            r[`STX_ST_WD_BIT]       = s.wdL;
            r[`STX_ST_ADC_BIT]      = s.adcL;
            r[`STX_ST_SIG_BIT]      = s.sigL;
            r[`STX_ST_ACT_BIT]      = s.drv;
            r[`STX_ST_ROLL_LSB +: 8] = s.roll;
         end
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   assign busReq          = avs_read | avs_write;
   assign avs_waitrequest = busReq & ~st.ack;
   assign avs_readdata    = st.rdata;
   assign sentData        = st.line;
   assign sentDriveEn     = st.drv;
   assign sentMode        = (st.dos == `STX_DOS_SENT); // R1
   // latched faults and live recoverable faults both pull the band
   assign faultNow = st.wdL | st.adcL | st.sigL | offsetFault | cordicOverflow | fieldRangeFault; // R14 R15 R16
   assign angleOut = faultNow ? {12{st.failure_band_select}} : angle; // R17
   assign rollOut  = st.rcDis ? 8'h00 : st.roll; // R19
   assign curNib   = (st.idx == 3'h7) ? fcrc.crc : st.nib[st.idx]; // R18
   assign segEnd   = tick && (st.cnt == segLen(st.ph, curNib, st.pl) - 8'h01);
   assign ftNext   = st.ft + 9'h001;

   always_comb begin
      next_st = st;
      startFrame = 1'b0;
      // bus: first cycle fetches, second cycle completes
      next_st.ack = busReq & ~st.ack;
      if (busReq && !st.ack) begin
         next_st.rdata = readMux(st, avs_address);
      end
      if (avs_write && st.ack) begin
         unique case (avs_address)
            `STX_CTRL_OFS: begin
               next_st.dos   = avs_writedata[`STX_DOS_LSB +: 2];
               next_st.esm   = avs_writedata[`STX_ESM_BIT];
               next_st.rcDis = avs_writedata[`STX_RCDIS_BIT];
               next_st.pp    = avs_writedata[`STX_PP_BIT];
               next_st.failure_band_select   = avs_writedata[`STX_FBS_BIT];
               next_st.tk    = avs_writedata[`STX_TK_LSB +: 5];
            end
            `STX_MSG_OFS: begin
               next_st.mid = avs_writedata[`STX_MID_LSB +: 4];
               next_st.field_magnitude = avs_writedata[`STX_MAG_LSB +: 8];
            end
            default: ;
         endcase
      end
      // sticky faults, cleared only by reset
      next_st.wdL  = st.wdL | watchdogFault; // R14
      next_st.adcL = st.adcL | adcCheckFault; // R15
      next_st.sigL = st.sigL | signatureFault; // R15
      if (!sentMode) begin
         next_st.ph = stx_pkg::PH_IDLE; // R1
      end else begin
         unique case (st.ph)
            stx_pkg::PH_IDLE: startFrame = 1'b1; // R2
            stx_pkg::PH_SYNC, stx_pkg::PH_NIB, stx_pkg::PH_PAUSE: begin
               if (tick) begin
                  next_st.ft  = ftNext;
                  next_st.cnt = st.cnt + 8'h01;
               end
               if (segEnd) begin
                  next_st.cnt = 8'h00;
                  if (st.ph == stx_pkg::PH_SYNC) begin
                     next_st.ph  = stx_pkg::PH_NIB; // R3
                     next_st.idx = 3'h0;
                  end else if (st.ph == stx_pkg::PH_NIB && st.idx != 3'h7) begin
                     next_st.idx = st.idx + 3'h1;
                  end else begin
                     if (st.ph == stx_pkg::PH_NIB) begin
                        next_st.roll = st.roll + 8'h01; // R11
                     end
                     if (st.ph == stx_pkg::PH_NIB && st.pp && ftNext < `STX_FRAME_TICKS) begin
                        next_st.ph = stx_pkg::PH_PAUSE; // R13
                        next_st.pl = 8'(`STX_FRAME_TICKS - ftNext);
                     end else begin
                        startFrame = 1'b1; // R2
                     end
                  end
               end
            end
         endcase
      end
      if (startFrame) begin
         // telegram contents frozen for the whole frame
         next_st.ph     = stx_pkg::PH_SYNC; // R3
         next_st.cnt    = 8'h00;
         next_st.ft     = 9'h000;
         next_st.idx    = 3'h0;
         next_st.nib[0] = {st.esm && st.msgIdx == 4'h0, // R8
                           st.esm && (st.msgIdx == 4'h0 ? msgLive[15] : st.msgw[4'hf - st.msgIdx]), // R10
                           1'b0, faultNow}; // R7
         next_st.nib[1] = angleOut[11:8]; // R6
         next_st.nib[2] = angleOut[7:4];
         next_st.nib[3] = angleOut[3:0];
         next_st.nib[4] = rollOut[7:4]; // R19
         next_st.nib[5] = rollOut[3:0];
         next_st.nib[6] = ~angleOut[11:8]; // R6
         next_st.msgIdx = st.esm ? st.msgIdx + 4'h1 : 4'h0; // R8
         if (st.msgIdx == 4'h0) begin
            next_st.msgw = msgLive;
         end
      end
      if (st.rcDis) begin
         next_st.roll = 8'h00; // R12
      end
      next_st.drv  = (next_st.ph != stx_pkg::PH_IDLE); // R1
      next_st.line = next_st.drv && (next_st.cnt >= `STX_LOW_TICKS); // R4
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st       <= '0;
         st.ph    <= stx_pkg::PH_IDLE;
         st.dos   <= 2'(`STX_CTRL_RESET >> `STX_DOS_LSB);
         st.esm   <= 1'b0; // R10
         st.mid   <= 4'h0;
         st.field_magnitude   <= 8'h00;
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   AST_OFF_IDLE: assert property (!sentMode |=> !sentDriveEn) // R1
      else $error("line driven outside sent mode");
   AST_SYNC_LEN: assert property ((st.ph == stx_pkg::PH_SYNC && segEnd) |-> st.cnt == 8'h37) // R3
      else $error("sync pulse not 56 ticks");
   AST_NIB_SHAPE: assert property ((st.ph == stx_pkg::PH_NIB) |-> (sentData == (st.cnt >= 8'h05))) // R4
      else $error("nibble low phase not 5 ticks");
   AST_NIB_LEN: assert property ((st.ph == stx_pkg::PH_NIB && segEnd) |-> st.cnt == 8'h0b + {4'h0, curNib}) // R4
      else $error("nibble length not 12 plus value");
   AST_INVERT: assert property ((st.ph != stx_pkg::PH_IDLE) |-> st.nib[6] == ~st.nib[1]) // R6
      else $error("nibble 7 not inverse of nibble 2");
   AST_STATUS_B1: assert property ((st.ph != stx_pkg::PH_IDLE) |-> !st.nib[0][1]) // R7
      else $error("status bit 1 set");
   AST_ROLL_STEP: assert property ((st.ph == stx_pkg::PH_NIB && st.idx == 3'h7 && segEnd && !st.rcDis)
                                   |=> st.roll == $past(st.roll) + 8'h01) // R11
      else $error("rolling counter did not step");
   AST_ROLL_ZERO: assert property ((startFrame && st.rcDis) |=> st.nib[4] == 4'h0 && st.nib[5] == 4'h0) // R19
      else $error("disabled counter not zero");
   AST_PAUSE_272: assert property ((st.ph == stx_pkg::PH_PAUSE && segEnd) |-> st.ft == 9'h10f) // R13
      else $error("paused telegram not 272 ticks");
   AST_WD_STICKY: assert property (st.wdL |=> st.wdL ##1 st.wdL) // R14
      else $error("watchdog error cleared without reset");
   AST_BAND: assert property ((startFrame && st.adcL) |=> st.nib[1] == {4{st.failure_band_select}} && st.nib[0][0]) // R15
      else $error("adc fault not in failure band");
   AST_NO_MSG: assert property ((startFrame && !st.esm) |=> st.nib[0][3:2] == 2'h0) // R10
      else $error("message bits sent while disabled");
   AST_BUS_WAIT: assert property ((busReq && !st.ack) |-> avs_waitrequest ##1 (!busReq || !avs_waitrequest))
      else $error("bus answer not after one wait state");

   COV_PAUSE: cover property (st.ph == stx_pkg::PH_PAUSE && segEnd);
   COV_MSG_START: cover property (startFrame && st.esm && st.msgIdx == 4'h0);
   COV_ROLL_WRAP: cover property (st.roll == 8'hff ##[1:1000] st.roll == 8'h00);
   COV_BAND_UP: cover property (startFrame && faultNow && st.failure_band_select);
endmodule

/* File: stx_ecu_model.sv */
// Purpose: behavioural sent receiver at the far end of the line
// Assumes: a pull-up holds the released line high
// Notes:   decodes on falling edges; tick recalibrated from every sync
`timescale 1ns/1ps
module stx_ecu_model (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // sent line
   input  wire logic        sentData,
   input  wire logic        sentDriveEn,
   // decoded telegram
   output logic      [31:0] frameNibs,
   output logic      [15:0] frameCount,
   output logic      [15:0] syncClks,
   output logic      [9:0]  frameTicks
);
   logic        lineLevel;
   logic        prevLine;
   logic [31:0] acc;
   int          gap;
   int          since;
   int          sc;
   int          k;

   assign lineLevel = sentDriveEn ? sentData : 1'b1;

   // interval in clocks rounded to whole ticks of the last sync
   function automatic int ticks(input int c);
      return (c * 112 + sc) / (2 * sc);
   endfunction

   always @(posedge mclk) begin
      prevLine <= lineLevel;
      gap = gap + 1;
      since = since + 1;
      if (reset || !sentDriveEn) begin
         k = -1;
         if (reset) frameCount <= 16'h0000;
      end else if (prevLine && !lineLevel) begin
         if (k < 0) begin
            since = 0;
            k = 0;
         end else if (k == 0) begin
            sc = gap;
            syncClks <= 16'(gap);
            k = 1;
         end else if (k <= 8) begin
            acc = {acc[27:0], 4'(ticks(gap) - 12)};
            if (k == 8) begin
               frameNibs <= acc;
               frameCount <= frameCount + 16'h0001;
            end
            k++;
         end else if ((gap - sc) * 28 <= sc && (sc - gap) * 28 <= sc) begin
            // no pause: the interval just ended was the next sync
            frameTicks <= 10'(ticks(since - gap));
            since = gap;
            sc = gap;
            syncClks <= 16'(gap);
            k = 1;
         end else begin
            frameTicks <= 10'(ticks(since));
            since = 0;
            k = 0;
         end
         gap = 0;
      end
   end
endmodule

/* File: testbench.sv */
// Purpose: self-checking bench for the sent transmitter
// Assumes: receiver model decodes the line; bus is avalon-mm
// Notes:   settings are frozen per telegram, so checks look two telegrams on
`timescale 1ns/1ps
`include "stx_cfg.svh"
module testbench;
   logic        mclk;
   logic        reset;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [11:0] angle;
   logic [5:0]  flt;
   logic        sentData;
   logic        sentDriveEn;
   logic [31:0] frameNibs;
   logic [15:0] frameCount;
   logic [15:0] syncClks;
   logic [9:0]  frameTicks;
   logic [31:0] rd;
   int          fails;
   int          checks_done;

   stx_sent_tx stx_sent_tx_i (.mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .angle(angle), .watchdogFault(flt[0]), .adcCheckFault(flt[1]),
      .signatureFault(flt[2]), .offsetFault(flt[3]), .cordicOverflow(flt[4]), .fieldRangeFault(flt[5]),
      .sentData(sentData), .sentDriveEn(sentDriveEn));

   stx_ecu_model stx_ecu_model_i (.mclk(mclk), .reset(reset), .sentData(sentData), .sentDriveEn(sentDriveEn),
      .frameNibs(frameNibs), .frameCount(frameCount), .syncClks(syncClks), .frameTicks(frameTicks));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic tally_and_finish;
      if (fails == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic expect_eq(input string what, input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, want, seen);
      end
   endtask

   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      // look between edges so the combinational waitrequest is settled
      do begin
         @(negedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      @(posedge mclk);
      rd = avs_readdata;
      fails += (n >= 20);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic wait_frames(input int n);
      logic [15:0] c;
      int          t;
      repeat (n) begin
         c = frameCount;
         t = 0;
         while (frameCount === c && t < 20000) begin
            @(posedge mclk);
            t++;
         end
         fails += (t >= 20000);
      end
   endtask

   // augmented form: multiply by x^4, then add the nibble; zero nibble last
   function automatic logic [3:0] crc4(input logic [23:0] d, input int n);
      logic [3:0] c;
      c = 4'h5;
      for (int i = n; i >= 0; i--) begin
         for (int j = 0; j < 4; j++)
            c = {c[2:0], 1'b0} ^ (c[3] ? 4'hd : 4'h0);
         if (i > 0)
            c = c ^ d[4*i-1 -: 4];
      end
      return c;
   endfunction

   function automatic logic [31:0] frame(input logic [3:0] st, input logic [11:0] ang, input logic [7:0] cnt);
      logic [23:0] d;
      d = {ang, cnt, ~ang[11:8]};
      return {st, d, crc4(d, 6)};
   endfunction

   task automatic t_reset;
      expect_eq("drive enable", sentDriveEn, 32'h0);
      bus(1'b0, `STX_CTRL_OFS, 32'h0);
      expect_eq("ctrl", rd, `STX_CTRL_RESET);
      bus(1'b0, `STX_MSG_OFS, 32'h0);
      expect_eq("msg", rd, `STX_MSG_RESET);
      bus(1'b1, `STX_STAT_OFS, 32'hffff_ffff);
      bus(1'b0, `STX_STAT_OFS, 32'h0);
      expect_eq("status", rd, 32'h0);
      bus(1'b0, 4'hc, 32'h0);
      expect_eq("unmapped", rd, 32'h0);
   endtask

   task automatic t_basic;
      logic [7:0] c0;
      angle <= 12'h3c1;
      bus(1'b1, `STX_CTRL_OFS, 32'h0000_0003);
      repeat (3) @(negedge mclk);
      expect_eq("drive enable", sentDriveEn, 32'h1);
      wait_frames(2);
      c0 = frameNibs[15:8];
      wait_frames(1);
      expect_eq("telegram", frameNibs, frame(4'h0, 12'h3c1, c0 + 8'h01));
      expect_eq("sync clocks", 32'(syncClks >= 16'd1679 && syncClks <= 16'd1681), 32'h1);
   endtask

   task automatic t_pause;
      bus(1'b1, `STX_CTRL_OFS, 32'h0);
      repeat (3) @(negedge mclk);
      expect_eq("drive enable", sentDriveEn, 32'h0);
      bus(1'b1, `STX_CTRL_OFS, 32'h0000_181b);
      wait_frames(3);
      expect_eq("telegram", frameNibs, frame(4'h0, 12'h3c1, 8'h00));
      expect_eq("frame ticks", frameTicks, 32'h110);
      expect_eq("sync clocks", 32'(syncClks >= 16'd1259 && syncClks <= 16'd1261), 32'h1);
   endtask

   task automatic t_msg;
      logic [15:0] w;
      logic [3:0]  st;
      int          n;
      angle <= 12'h000;
      bus(1'b1, `STX_MSG_OFS, 32'h0000_5a09);
      bus(1'b1, `STX_CTRL_OFS, 32'h0000_180f);
      n = 0;
      do begin
         wait_frames(1);
         n++;
      end while (frameNibs[31] !== 1'b1 && n < 4);
      for (int i = 0; i < 16; i++) begin
         if (i > 0)
            wait_frames(1);
         st = frameNibs[31:28];
         w = {w[14:0], st[2]};
         expect_eq("message start", st[3], i == 0);
      end
      expect_eq("message", w, {4'h9, 8'h5a, crc4(24'h00095a, 3)});
   endtask

   task automatic t_faults;
      angle <= 12'h3c1;
      flt <= 6'h08;
      bus(1'b1, `STX_CTRL_OFS, 32'h0000_180b);
      wait_frames(2);
      expect_eq("telegram", frameNibs, frame(4'h1, 12'h000, 8'h00));
      flt <= 6'h30;
      bus(1'b1, `STX_CTRL_OFS, 32'h0000_182b);
      wait_frames(2);
      expect_eq("telegram", frameNibs, frame(4'h1, 12'hfff, 8'h00));
      flt <= 6'h00;
      wait_frames(2);
      expect_eq("telegram", frameNibs, frame(4'h0, 12'h3c1, 8'h00));
      flt <= 6'h07;
      @(posedge mclk);
      flt <= 6'h00;
      wait_frames(2);
      expect_eq("telegram", frameNibs, frame(4'h1, 12'hfff, 8'h00));
      bus(1'b0, `STX_STAT_OFS, 32'h0);
      expect_eq("status", rd, 32'h0000_001f);
      reset <= 1'b1;
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      bus(1'b0, `STX_STAT_OFS, 32'h0);
      expect_eq("status", rd, 32'h0);
      expect_eq("drive enable", sentDriveEn, 32'h0);
   endtask

   initial begin
      reset = 1'b1;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      angle = 12'h000;
      flt = 6'h00;
      fails = 0;
      checks_done = 0;
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      t_reset;
      t_basic;
      t_pause;
      t_msg;
      t_faults;
      tally_and_finish;
   end

   // telegrams run about four to six thousand clocks each; the message scenario alone needs sixteen
   initial begin
      repeat (150000) @(posedge mclk);
      fails++;
      tally_and_finish;
   end
endmodule
